// >>> src/sfb_front_end.v
`timescale 1ns/1ps
`default_nettype none
`include "sfb_regs.vh"
module sfb_front_end
(
    input wire clk,
    input wire resetn,
    input wire por_active,
    input wire quad_enable_bit,
    input wire sclk,
    input wire cs_n,
    input wire data_line_0_in,
    output reg data_line_0_out,
    output reg data_line_0_oe_n,
    input wire data_line_1_in,
    output reg data_line_1_out,
    output reg data_line_1_oe_n,
    input wire data_line_2_in,
    output reg data_line_2_out,
    output reg data_line_2_oe_n,
    input wire data_line_3_in,
    output reg data_line_3_out,
    output reg data_line_3_oe_n,
    output reg four_wire_command_mode,
    output wire paused,
    output reg [7:0] cmd_code,
    output reg cmd_strobe,
    output reg [23:0] addr,
    output reg addr_strobe,
    output reg [8:0] sector_index,
    output reg [5:0] half_block_index,
    output reg [4:0] block_index,
    output reg [7:0] wr_data,
    output reg wr_valid,
    input wire wr_ready,
    input wire [7:0] rd_data,
    input wire rd_valid,
    output wire rd_ready
);
// ****************
// pin synchronisers
// ****************
// the bench link clock is 160 ns, so two flops at 10 ns leave ample margin
reg [6:0] sync_a;
reg [6:0] sync_b;
wire [6:0] pins_raw;
assign pins_raw = {por_active, sclk, cs_n, data_line_3_in, data_line_2_in,
                   data_line_1_in, data_line_0_in};
// select rests low in reset so a select held low since power-up shows no falling edge
localparam [6:0] SYNC_IDLE = 7'h6F;
genvar gi;
generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_sync
        always @(posedge clk or negedge resetn)
        begin
            if (!resetn)
            begin
                sync_a[gi] <= SYNC_IDLE[gi];
                sync_b[gi] <= SYNC_IDLE[gi];
            end
            else
            begin
                sync_a[gi] <= pins_raw[gi];
                sync_b[gi] <= sync_a[gi];
            end
        end
    end
endgenerate
wire por_s;
wire sclk_s;
wire cs_s;
wire [3:0] dl_s;
assign por_s = sync_b[6];
assign sclk_s = sync_b[5];
assign cs_s = sync_b[4];
assign dl_s = sync_b[3:0];
reg sclk_d;
reg cs_d;
reg armed;
wire sclk_rise;
wire sclk_fall;
wire cs_fall;
assign sclk_rise = sclk_s & ~sclk_d;
assign sclk_fall = ~sclk_s & sclk_d;
assign cs_fall = ~cs_s & cs_d;
// selection also needs pause released; pause only exists without quad enable
reg hold_state;
wire hold_req;
assign hold_req = ~dl_s[3] & ~quad_enable_bit & ~four_wire_command_mode;
// quad enable cuts the pause at once, not only at the next low clock
assign paused = hold_state & ~quad_enable_bit & ~four_wire_command_mode;
wire active;
assign active = armed & ~cs_s & ~por_s & ~paused;
// ****************
// transfer state
// ****************
reg [2:0] phase;
reg [1:0] width;
reg [7:0] shreg;
reg [4:0] bitcnt;
reg [7:0] dummy_cnt;
reg rst_enabled;
reg need_addr;
reg need_dummy;
reg is_read;
reg [7:0] obyte;
reg obyte_ok;
reg [1:0] out_lines;
reg [23:0] ashift;
reg [2:0] shift_n;
reg [4:0] unit_bits;
// bits per clock and bits per unit
always @*
begin
    shift_n = 3'h1;
    if (width == `SFB_W_DUAL)
        shift_n = 3'h2;
    else if (width == `SFB_W_QUAD)
        shift_n = 3'h4;
    unit_bits = (phase == `SFB_PH_ADDR) ? 5'h18 : 5'h08;
end
// next shift content for the data lines of the current width
reg [7:0] next_shreg;
always @*
begin
    case (shift_n)
        3'h2: next_shreg = {shreg[5:0], dl_s[1:0]};
        3'h4: next_shreg = {shreg[3:0], dl_s[3:0]};
        default: next_shreg = {shreg[6:0], dl_s[0]};
    endcase
end
reg [23:0] next_ashift;
always @*
begin
    case (shift_n)
        3'h2: next_ashift = {ashift[21:0], dl_s[1:0]};
        3'h4: next_ashift = {ashift[19:0], dl_s[3:0]};
        default: next_ashift = {ashift[22:0], dl_s[0]};
    endcase
end
// ****************
// two-entry buffer toward the host
// ****************
reg [7:0] buf_data [0:1];
reg [1:0] buf_cnt;
reg buf_rd;
reg buf_wr;
// nothing is taken while deselected, since deselect flushes the buffer
assign rd_ready = (buf_cnt != 2'h2) & ~cs_s;
wire buf_take;
wire buf_pop;
wire need_byte;
assign need_byte = ~obyte_ok | (bitcnt >= 5'h08);
assign buf_take = rd_valid & rd_ready;
assign buf_pop = (phase == `SFB_PH_DATA_OUT) & active & sclk_fall & need_byte
                 & (buf_cnt != 2'h0);
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        buf_cnt <= 2'h0;
        buf_rd <= 1'b0;
        buf_wr <= 1'b0;
        buf_data[0] <= 8'h00;
        buf_data[1] <= 8'h00;
    end
    else if (cs_s)
    begin
        // a new read never starts on bytes fetched for an aborted one
        buf_cnt <= 2'h0;
        buf_rd <= 1'b0;
        buf_wr <= 1'b0;
    end
    else
    begin
        if (buf_take)
        begin
            buf_data[buf_wr] <= rd_data;
            buf_wr <= ~buf_wr;
        end
        if (buf_pop)
            buf_rd <= ~buf_rd;
        buf_cnt <= buf_cnt + {1'b0, buf_take} - {1'b0, buf_pop};
    end
end
// ****************
// main sequencer
// ****************
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        sclk_d <= 1'b1;
        cs_d <= 1'b0;
        armed <= 1'b0;
        hold_state <= 1'b0;
        four_wire_command_mode <= 1'b0;
        phase <= `SFB_PH_CMD;
        width <= `SFB_W_SINGLE;
        shreg <= 8'h00;
        ashift <= 24'h000000;
        bitcnt <= 5'h00;
        dummy_cnt <= 8'h00;
        rst_enabled <= 1'b0;
        need_addr <= 1'b0;
        need_dummy <= 1'b0;
        is_read <= 1'b0;
        obyte <= 8'h00;
        obyte_ok <= 1'b0;
        out_lines <= 2'h0;
        cmd_code <= 8'h00;
        cmd_strobe <= 1'b0;
        addr <= 24'h000000;
        addr_strobe <= 1'b0;
        sector_index <= 9'h000;
        half_block_index <= 6'h00;
        block_index <= 5'h00;
        wr_data <= 8'h00;
        wr_valid <= 1'b0;
    end
    else
    begin
        sclk_d <= sclk_s;
        cs_d <= cs_s;
        cmd_strobe <= 1'b0;
        addr_strobe <= 1'b0;
        if (wr_ready)
            wr_valid <= 1'b0;
        if (por_s)
        begin
            // arming, four-wire mode and reset enable held clear while the detector is active
            armed <= 1'b0;
            four_wire_command_mode <= 1'b0;
            rst_enabled <= 1'b0;
        end
        else if (cs_fall)
            armed <= 1'b1;
        if (cs_s)
            hold_state <= 1'b0;
        else if (~sclk_s)
            hold_state <= hold_req; // pause request taken only with clock low
        if (cs_s | ~active)
        begin
            if (cs_s | por_s)
            begin
                // deselect ends any transfer; clock idle level is don't care
                phase <= `SFB_PH_CMD;
                bitcnt <= 5'h00;
                obyte_ok <= 1'b0;
                out_lines <= 2'h0;
                width <= four_wire_command_mode ? `SFB_W_QUAD : `SFB_W_SINGLE;
            end
        end
        else if (sclk_rise && phase != `SFB_PH_DATA_OUT && phase != `SFB_PH_IDLE)
        begin
            shreg <= next_shreg;
            ashift <= next_ashift;
            if (phase == `SFB_PH_DUMMY)
            begin
                dummy_cnt <= dummy_cnt - 8'h01;
                if (dummy_cnt == 8'h01)
                begin
                    phase <= is_read ? `SFB_PH_DATA_OUT : `SFB_PH_DATA_IN;
                    // output commands took their address on one line; data goes wide
                    if (cmd_code == `SFB_CMD_DUAL_OUT)
                        width <= `SFB_W_DUAL;
                    else if (cmd_code == `SFB_CMD_QUAD_OUT)
                        width <= `SFB_W_QUAD;
                end
            end
            else if (bitcnt + {2'b00, shift_n} >= unit_bits)
            begin
                bitcnt <= 5'h00;
                if (phase == `SFB_PH_CMD)
                begin
                    cmd_code <= next_shreg;
                    cmd_strobe <= 1'b1;
                    phase <= `SFB_PH_IDLE;
                    need_addr <= 1'b0;
                    need_dummy <= 1'b0;
                    is_read <= 1'b0;
                    rst_enabled <= 1'b0;
                    case (next_shreg)
                        `SFB_CMD_DUAL_OUT, `SFB_CMD_DUAL_IO, `SFB_CMD_DUAL_ID:
                        begin
                            phase <= `SFB_PH_ADDR;
                            need_addr <= 1'b1;
                            need_dummy <= 1'b1;
                            is_read <= 1'b1;
                            if (next_shreg != `SFB_CMD_DUAL_OUT)
                                width <= `SFB_W_DUAL;
                        end
                        `SFB_CMD_QUAD_OUT, `SFB_CMD_QUAD_IO, `SFB_CMD_QUAD_WORD,
                        `SFB_CMD_QUAD_ID, `SFB_CMD_QUAD_PP:
                        begin
                            if (quad_enable_bit)
                            begin
                                phase <= `SFB_PH_ADDR;
                                need_addr <= 1'b1;
                                need_dummy <= (next_shreg != `SFB_CMD_QUAD_PP);
                                is_read <= (next_shreg != `SFB_CMD_QUAD_PP);
                                if (next_shreg != `SFB_CMD_QUAD_OUT)
                                    width <= `SFB_W_QUAD;
                            end
                        end
                        `SFB_CMD_ENTER_4W:
                            if (quad_enable_bit && !four_wire_command_mode)
                                four_wire_command_mode <= 1'b1;
                        `SFB_CMD_EXIT_4W:
                            four_wire_command_mode <= 1'b0;
                        `SFB_CMD_RST_EN:
                            rst_enabled <= 1'b1;
                        `SFB_CMD_RST:
                            if (rst_enabled)
                                four_wire_command_mode <= 1'b0;
                        default:
                            phase <= `SFB_PH_IDLE;
                    endcase
                end
                else if (phase == `SFB_PH_ADDR)
                begin
                    addr <= next_ashift & `SFB_ADDR_TOP;
                    addr_strobe <= 1'b1;
                    sector_index <= next_ashift[`SFB_SECTOR_MSB:`SFB_SECTOR_LSB];
                    half_block_index <= next_ashift[`SFB_SECTOR_MSB:`SFB_HALF_LSB];
                    block_index <= next_ashift[`SFB_SECTOR_MSB:`SFB_BLOCK_LSB];
                    if (need_dummy)
                    begin
                        phase <= `SFB_PH_DUMMY;
                        dummy_cnt <= `SFB_DUMMY_CLKS;
                    end
                    else
                        phase <= `SFB_PH_DATA_IN;
                    if (!is_read && width == `SFB_W_SINGLE)
                        width <= `SFB_W_QUAD; // program data on four lines
                end
                else
                begin
                    // a byte lost here if the sink stalls past one byte time
                    wr_data <= next_shreg;
                    wr_valid <= 1'b1;
                end
            end
            else
                bitcnt <= bitcnt + {2'b00, shift_n};
        end
        else if (sclk_fall && phase == `SFB_PH_DATA_OUT)
        begin
            // outputs move only after a falling edge
            out_lines <= (shift_n == 3'h4) ? 2'h3 : ((shift_n == 3'h2) ? 2'h2 : 2'h1);
            // the next byte follows on the very fall after the last bits, no gap
            if (need_byte)
            begin
                if (buf_cnt != 2'h0)
                begin
                    obyte <= buf_data[buf_rd];
                    obyte_ok <= 1'b1;
                    bitcnt <= {2'b00, shift_n};
                end
                else
                begin
                    obyte_ok <= 1'b0;
                    bitcnt <= 5'h00;
                end
            end
            else
            begin
                obyte <= (shift_n == 3'h4) ? {obyte[3:0], 4'h0} :
                         ((shift_n == 3'h2) ? {obyte[5:0], 2'h0} : {obyte[6:0], 1'b0});
                bitcnt <= bitcnt + {2'b00, shift_n};
            end
        end
    end
end
// ****************
// pin drivers
// ****************
always @(posedge clk or negedge resetn)
begin
    if (!resetn)
    begin
        data_line_0_out <= 1'b0;
        data_line_1_out <= 1'b0;
        data_line_2_out <= 1'b0;
        data_line_3_out <= 1'b0;
        data_line_0_oe_n <= 1'b1;
        data_line_1_oe_n <= 1'b1;
        data_line_2_oe_n <= 1'b1;
        data_line_3_oe_n <= 1'b1;
    end
    else
    begin
        // released whenever deselected or paused
        data_line_0_oe_n <= ~(active & obyte_ok & out_lines[1]);
        data_line_1_oe_n <= ~(active & obyte_ok & (out_lines != 2'h0));
        data_line_2_oe_n <= ~(active & obyte_ok & (out_lines == 2'h3));
        data_line_3_oe_n <= ~(active & obyte_ok & (out_lines == 2'h3));
        data_line_3_out <= obyte[7];
        data_line_2_out <= obyte[6];
        if (out_lines == 2'h3)
        begin
            data_line_1_out <= obyte[5];
            data_line_0_out <= obyte[4];
        end
        else
        begin
            data_line_1_out <= obyte[7];
            data_line_0_out <= obyte[6];
        end
    end
end
endmodule
`default_nettype wire

// >>> src/sfb_regs.vh
`ifndef SFB_REGS_VH
`define SFB_REGS_VH
// ****************
// command codes
// ****************
`define SFB_CMD_DUAL_OUT 8'h3B
`define SFB_CMD_DUAL_IO 8'hBB
`define SFB_CMD_DUAL_ID 8'h92
`define SFB_CMD_QUAD_OUT 8'h6B
`define SFB_CMD_QUAD_IO 8'hEB
`define SFB_CMD_QUAD_WORD 8'hE7
`define SFB_CMD_QUAD_ID 8'h94
`define SFB_CMD_QUAD_PP 8'h32
`define SFB_CMD_ENTER_4W 8'h38
`define SFB_CMD_EXIT_4W 8'hFF
`define SFB_CMD_RST_EN 8'h66
`define SFB_CMD_RST 8'h99
// ****************
// address map
// ****************
`define SFB_ADDR_TOP 24'h1FFFFF
`define SFB_SECTOR_MSB 20
`define SFB_SECTOR_LSB 12
`define SFB_HALF_LSB 15
`define SFB_BLOCK_LSB 16
// ****************
// bus width codes for one, two and four lines per clock
// ****************
`define SFB_W_SINGLE 2'h0
`define SFB_W_DUAL 2'h1
`define SFB_W_QUAD 2'h2
// ****************
// phases
// ****************
`define SFB_PH_CMD 3'h0
`define SFB_PH_ADDR 3'h1
`define SFB_PH_DUMMY 3'h2
`define SFB_PH_DATA_OUT 3'h3
`define SFB_PH_DATA_IN 3'h4
`define SFB_PH_IDLE 3'h5
`define SFB_DUMMY_CLKS 8'h08
`endif

// >>> verification/sfb_front_end_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfb_regs.vh"
// ****************
// bench
// ****************
module sfb_front_end_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic por_active = 1'b0;
    logic quad = 1'b0;
    logic rd_valid = 1'b0;
    logic wr_ready = 1'b1;
    logic [7:0] rd_data = 8'hA0;
    wire sclk, cs_n, mode, paused, cmd_strobe, addr_strobe, wr_valid, rd_ready;
    wire [3:0] host_d, host_en, line_in, line_out, line_oe_n;
    wire [7:0] cmd_code, wr_data;
    wire [23:0] addr;
    wire [8:0] sector;
    wire [5:0] half;
    wire [4:0] block;
    int miscompares = 0;
    int compares = 0;
    int strobes = 0;
    int cycles = 0;
    int n;
    always #5 clk = ~clk;
    // lines 2 and 3 carry pull-ups, lines 0 and 1 do not
    assign line_in[0] = !line_oe_n[0] ? line_out[0] : host_d[0];
    assign line_in[1] = !line_oe_n[1] ? line_out[1] : host_d[1];
    assign line_in[2] = !line_oe_n[2] ? line_out[2] : (host_en[2] ? host_d[2] : 1'b1);
    assign line_in[3] = !line_oe_n[3] ? line_out[3] : (host_en[3] ? host_d[3] : 1'b1);
    sfb_host_model i_sfb_host_model (.clk(clk), .lines(line_in), .sclk(sclk), .cs_n(cs_n),
        .host_d(host_d), .host_en(host_en));
    sfb_front_end i_sfb_front_end (.clk(clk), .resetn(resetn), .por_active(por_active),
        .quad_enable_bit(quad), .sclk(sclk), .cs_n(cs_n),
        .data_line_0_in(line_in[0]), .data_line_0_out(line_out[0]), .data_line_0_oe_n(line_oe_n[0]),
        .data_line_1_in(line_in[1]), .data_line_1_out(line_out[1]), .data_line_1_oe_n(line_oe_n[1]),
        .data_line_2_in(line_in[2]), .data_line_2_out(line_out[2]), .data_line_2_oe_n(line_oe_n[2]),
        .data_line_3_in(line_in[3]), .data_line_3_out(line_out[3]), .data_line_3_oe_n(line_oe_n[3]),
        .four_wire_command_mode(mode), .paused(paused), .cmd_code(cmd_code),
        .cmd_strobe(cmd_strobe), .addr(addr), .addr_strobe(addr_strobe), .sector_index(sector),
        .half_block_index(half), .block_index(block), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cmd_strobe === 1'b1)
            strobes <= strobes + 1;
        if (rd_valid && rd_ready === 1'b1)
            rd_data <= rd_data + 8'h01;
        if (cycles == 60000)
        begin
            miscompares++;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] code, input int w, input logic cpol, input int more);
        n = strobes;
        i_sfb_host_model.select(cpol);
        i_sfb_host_model.shift({24'h0, code}, 8, w);
        i_sfb_host_model.deselect();
        check_val(strobes - n, more);
    endtask
    task automatic test_arm;
        n = strobes;
        i_sfb_host_model.shift({24'h0, `SFB_CMD_DUAL_OUT}, 8, 1);
        i_sfb_host_model.ticks(8);
        check_val(strobes - n, 32'h0);
        frame(`SFB_CMD_DUAL_OUT, 1, 1'b0, 1);
    endtask
    task automatic test_codes;
        logic [7:0] codes [8];
        int i;
        codes = '{`SFB_CMD_DUAL_OUT, `SFB_CMD_DUAL_IO, `SFB_CMD_DUAL_ID, `SFB_CMD_QUAD_OUT,
            `SFB_CMD_QUAD_IO, `SFB_CMD_QUAD_WORD, `SFB_CMD_QUAD_ID, `SFB_CMD_QUAD_PP};
        quad <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            frame(codes[i], 1, i[0], 1);
            check_val({24'h0, cmd_code}, {24'h0, codes[i]});
        end
    endtask
    task automatic test_addr(input logic [23:0] a, input logic [23:0] exp);
        i_sfb_host_model.select(1'b0);
        i_sfb_host_model.shift({24'h0, `SFB_CMD_DUAL_OUT}, 8, 1);
        i_sfb_host_model.shift({8'h0, a}, 24, 1);
        check_val({8'h0, addr}, {8'h0, exp});
        check_val({23'h0, sector}, {23'h0, exp[20:12]});
        check_val({26'h0, half}, {26'h0, exp[20:15]});
        check_val({27'h0, block}, {27'h0, exp[20:16]});
        i_sfb_host_model.deselect();
    endtask
    task automatic test_read(input logic [7:0] cmd, input int w);
        logic [31:0] got;
        int i;
        rd_data <= 8'hA0;
        i_sfb_host_model.select(1'b0);
        rd_valid <= 1'b1;
        i_sfb_host_model.shift({24'h0, cmd}, 8, 1);
        i_sfb_host_model.shift(32'h100, 24, 1);
        i_sfb_host_model.shift(32'h0, 8, 1);
        for (i = 0; i < 4; i++)
        begin
            i_sfb_host_model.fetch(8, w, got);
            check_val(got, 32'hA0 + i);
            // the stall after the first byte must fill the buffer without losing a word
            if (i == 0)
            begin
                i_sfb_host_model.ticks(40);
                check_val({31'h0, rd_ready}, 32'h0);
            end
        end
        check_val({28'h0, line_oe_n}, w == 4 ? 32'h0 : 32'hC);
        i_sfb_host_model.deselect();
        rd_valid <= 1'b0;
        check_val({28'h0, line_oe_n}, 32'hF);
    endtask
    task automatic test_program;
        quad <= 1'b1;
        wr_ready <= 1'b0;
        i_sfb_host_model.select(1'b0);
        i_sfb_host_model.shift({24'h0, `SFB_CMD_QUAD_PP}, 8, 1);
        i_sfb_host_model.shift(32'h01F000, 24, 4);
        check_val({8'h0, addr}, 32'h01F000);
        check_val({27'h0, block}, 32'h1);
        i_sfb_host_model.shift(32'h5A, 8, 4);
        check_val({31'h0, wr_valid}, 32'h1);
        check_val({24'h0, wr_data}, 32'h5A);
        wr_ready <= 1'b1;
        i_sfb_host_model.ticks(2);
        check_val({31'h0, wr_valid}, 32'h0);
        i_sfb_host_model.deselect();
    endtask
    task automatic test_four_wire;
        quad <= 1'b0;
        frame(`SFB_CMD_ENTER_4W, 1, 1'b0, 1);
        check_val({31'h0, mode}, 32'h0);
        quad <= 1'b1;
        frame(`SFB_CMD_ENTER_4W, 1, 1'b1, 1);
        check_val({31'h0, mode}, 32'h1);
        frame(`SFB_CMD_QUAD_OUT, 4, 1'b0, 1);
        check_val({24'h0, cmd_code}, {24'h0, `SFB_CMD_QUAD_OUT});
        frame(`SFB_CMD_EXIT_4W, 4, 1'b1, 1);
        check_val({31'h0, mode}, 32'h0);
        frame(`SFB_CMD_ENTER_4W, 1, 1'b0, 1);
        frame(`SFB_CMD_RST_EN, 4, 1'b0, 1);
        frame(`SFB_CMD_RST, 4, 1'b0, 1);
        check_val({31'h0, mode}, 32'h0);
    endtask
    task automatic test_por;
        frame(`SFB_CMD_ENTER_4W, 1, 1'b0, 1);
        por_active <= 1'b1;
        i_sfb_host_model.ticks(10);
        check_val({31'h0, mode}, 32'h0);
        // a frame sent under power-on reset, against the host's duty, must be ignored
        frame(`SFB_CMD_DUAL_OUT, 1, 1'b0, 0);
        por_active <= 1'b0;
        i_sfb_host_model.ticks(10);
        frame(`SFB_CMD_DUAL_OUT, 1, 1'b0, 1);
    endtask
    task automatic test_pause;
        quad <= 1'b0;
        i_sfb_host_model.select(1'b0);
        i_sfb_host_model.drive(4'h0, 4'h8);
        i_sfb_host_model.ticks(8);
        check_val({31'h0, paused}, 32'h1);
        quad <= 1'b1;
        i_sfb_host_model.ticks(8);
        check_val({31'h0, paused}, 32'h0);
        i_sfb_host_model.deselect();
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        check_val({28'h0, line_oe_n}, 32'hF);
        check_val({31'h0, mode}, 32'h0);
        check_val({31'h0, rd_ready}, 32'h1);
        test_arm;
        test_codes;
        test_addr(24'hFE8123, 24'h1E8123);
        test_addr(24'h1FFFFF, 24'h1FFFFF);
        test_read(`SFB_CMD_DUAL_OUT, 2);
        test_read(`SFB_CMD_QUAD_OUT, 4);
        test_program;
        test_four_wire;
        test_por;
        test_pause;
        complete_run;
    end
endmodule
`default_nettype wire

// >>> verification/sfb_front_end_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfb_regs.vh"
// ****************
// port properties
// ****************
module sfb_front_end_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_active,
    input wire logic quad_enable_bit,
    input wire logic cs_n,
    input wire logic data_line_0_oe_n,
    input wire logic data_line_1_oe_n,
    input wire logic data_line_2_oe_n,
    input wire logic data_line_3_oe_n,
    input wire logic four_wire_command_mode,
    input wire logic paused,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_strobe,
    input wire logic [23:0] addr,
    input wire logic addr_strobe,
    input wire logic [8:0] sector_index,
    input wire logic [5:0] half_block_index,
    input wire logic [4:0] block_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // six cycles cover the two-flop synchroniser plus the output register
    sequence deselected_s;
        cs_n [*6];
    endsequence
    sequence por_held_s;
        por_active [*6];
    endsequence
    strobe_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than one cycle");
    deselect_hiz_a: assert property (deselected_s |->
        data_line_0_oe_n && data_line_1_oe_n && data_line_2_oe_n && data_line_3_oe_n)
        else $error("a line is driven while deselected");
    enter_quad_a: assert property ($rose(four_wire_command_mode) |-> quad_enable_bit)
        else $error("four-wire mode entered with quad enable clear");
    enter_code_a: assert property ($rose(four_wire_command_mode) |->
        cmd_code == `SFB_CMD_ENTER_4W)
        else $error("four-wire mode entered without the enter code");
    exit_code_a: assert property ($fell(four_wire_command_mode) && !por_active |->
        cmd_code == `SFB_CMD_EXIT_4W || cmd_code == `SFB_CMD_RST)
        else $error("four-wire mode left without exit or reset");
    por_silent_a: assert property (por_held_s |-> !cmd_strobe && !addr_strobe)
        else $error("command taken while power-on reset active");
    addr_range_a: assert property (addr_strobe |-> addr[23:21] == 3'h0)
        else $error("address above the top of the array");
    index_map_a: assert property (addr_strobe |=> ##1
        (sector_index == addr[20:12] && half_block_index == addr[20:15]
        && block_index == addr[20:16]))
        else $error("sector or block index does not match address");
    pause_quad_a: assert property (quad_enable_bit |-> !paused)
        else $error("pause active while quad enable set");
    line2_quad_a: assert property (!data_line_2_oe_n |-> quad_enable_bit)
        else $error("line 2 driven with quad enable clear");
endmodule
bind sfb_front_end sfb_front_end_properties i_sfb_front_end_properties (
    .clk(clk), .resetn(resetn), .por_active(por_active), .quad_enable_bit(quad_enable_bit),
    .cs_n(cs_n), .data_line_0_oe_n(data_line_0_oe_n), .data_line_1_oe_n(data_line_1_oe_n),
    .data_line_2_oe_n(data_line_2_oe_n), .data_line_3_oe_n(data_line_3_oe_n),
    .four_wire_command_mode(four_wire_command_mode), .paused(paused), .cmd_code(cmd_code),
    .cmd_strobe(cmd_strobe), .addr(addr), .addr_strobe(addr_strobe),
    .sector_index(sector_index), .half_block_index(half_block_index),
    .block_index(block_index));
`default_nettype wire

// >>> verification/sfb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host controller
// ****************
module sfb_host_model (
    input wire logic clk,
    input wire logic [3:0] lines,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] host_d,
    output logic [3:0] host_en
);
    localparam int HALF = 8;
    logic idle_level = 1'b0;
    // chip select starts low: as if it never rose during power-up
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        host_d = 4'h0;
        host_en = 4'h0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic select(input logic cpol);
        idle_level <= cpol;
        sclk <= cpol;
        cs_n <= 1'b1;
        ticks(HALF);
        cs_n <= 1'b0;
        ticks(HALF);
    endtask
    task automatic deselect;
        sclk <= idle_level;
        host_en <= 4'h0;
        // released lines show the inverse so a stale value cannot pass
        host_d <= ~host_d;
        ticks(HALF);
        cs_n <= 1'b1;
        ticks(2 * HALF);
    endtask
    task automatic drive(input logic [3:0] d, input logic [3:0] en);
        host_d <= d;
        host_en <= en;
    endtask
    task automatic shift(input logic [31:0] val, input int nbits, input int w);
        int i;
        for (i = nbits - w; i >= 0; i -= w)
        begin
            sclk <= 1'b0;
            host_en <= 4'((32'h1 << w) - 1);
            host_d <= 4'((val >> i) & ((32'h1 << w) - 1));
            ticks(HALF);
            sclk <= 1'b1;
            ticks(HALF);
        end
    endtask
    task automatic fetch(input int nbits, input int w, output logic [31:0] val);
        int i;
        val = 32'h0;
        host_en <= 4'h0;
        for (i = 0; i < nbits; i += w)
        begin
            sclk <= 1'b0;
            ticks(HALF);
            val = (val << w) | {28'h0, lines & 4'((32'h1 << w) - 1)};
            sclk <= 1'b1;
            ticks(HALF);
        end
    endtask
endmodule
`default_nettype wire
